// File: common/homing_pkg.sv
// Constants and carriers for the codec homing control block
package homing_pkg;

  // Encoder homing frame
  localparam int FRAME_SAMPLES = 160;
  localparam int SAMPLE_BITS = 13;
  localparam int WORD_BITS = 16;
  localparam logic [WORD_BITS-1:0] ENC_HOME_WORD = 16'h0008;

  // Codec modes and parameter frames
  localparam int NUM_MODES = 8;
  localparam int MODE_W = 3;
  localparam int PAR_W = 244;
  localparam int LEN_W = 8;

  typedef logic [NUM_MODES-1:0][LEN_W-1:0] len_table_t;
  typedef logic [NUM_MODES-1:0][PAR_W-1:0] par_table_t;

  // Bits per frame, modes 0 to 7 (4.75 up to 12.2 kbit/s)
  localparam len_table_t PAR_LEN = {
    8'hF4, 8'hCC, 8'h9F, 8'h94, 8'h86, 8'h76, 8'h67, 8'h5F
  };

  // Bits covering linear prediction and first subframe, modes 0 to 3; whole frame for modes 4 to 7
  localparam len_table_t EARLY_LEN = {
    8'hF4, 8'hCC, 8'h9F, 8'h94, 8'h37, 8'h37, 8'h2E, 8'h30
  };

  // Decoder homing frames, one per mode, bit i holds s(i+1)
  localparam par_table_t DEC_HOME_DEFAULT = '0;

  // Sample carrier
  typedef struct packed {
    logic valid;
    logic first;
    logic last;
    logic [WORD_BITS-1:0] data;
  } smp_t;

  // Parameter frame carrier
  typedef struct packed {
    logic valid;
    logic [PAR_W-1:0] bits;
  } par_t;

  // Mask of the lowest n bits of a parameter frame
  function automatic logic [PAR_W-1:0] len_mask(input logic [LEN_W-1:0] n);
    logic [PAR_W-1:0] m;
    m = '0;
    for (int i = 0; i < PAR_W; i++) begin
      m[i] = (i < int'(n));
    end
    return m;
  endfunction

endpackage

// File: hdl/codec_homing_control.sv
// Homing frame detection, substitution and home reset for encoder and decoder
`timescale 1ns/10ps
`default_nettype none

module codec_homing_control
  import homing_pkg::*;
#(
  parameter int SAMPLES = FRAME_SAMPLES,
  parameter par_table_t DEC_HOME_FRAMES = DEC_HOME_DEFAULT
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Codec modes from the controller
  input wire logic [MODE_W-1:0] enc_mode,
  input wire logic [MODE_W-1:0] dec_mode,
  // Encoder: speech in, core parameters in, parameters out
  input wire smp_t enc_smp_in,
  input wire par_t enc_par_in,
  output par_t enc_par_out,
  output logic enc_home_det,
  output logic enc_home_rst,
  output logic enc_in_home,
  // Decoder: parameters in, core speech in, speech out
  input wire par_t dec_par_in,
  input wire smp_t dec_smp_in,
  output smp_t dec_smp_out,
  output logic dec_home_det,
  output logic dec_home_rst,
  output logic dec_in_home
);

  localparam int CNT_W = $clog2(SAMPLES + 1);
  localparam logic [CNT_W-1:0] LAST_IDX = CNT_W'(SAMPLES - 1);
  localparam logic [CNT_W-1:0] ONE_IDX = CNT_W'(1);

  initial begin
    if (SAMPLES < 2) begin
      $error("SAMPLES must be at least 2");
    end
    if (SAMPLE_BITS > WORD_BITS) begin
      $error("Sample wider than carrier word");
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Encoder input frame tracking

  logic [CNT_W-1:0] smp_cnt;
  logic in_frame;
  logic frame_match;
  logic frame_start_home;
  logic smp_is_home;
  logic frame_end;
  logic enc_hit;

  // Same word for all modes
  assign smp_is_home = (enc_smp_in.data == ENC_HOME_WORD);
  assign frame_end = enc_smp_in.valid && !enc_smp_in.first && in_frame &&
                     (smp_cnt == LAST_IDX);
  assign enc_hit = frame_end && frame_match && smp_is_home;

  // Count samples from the frame start marker
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      smp_cnt <= '0;
      in_frame <= 1'b0;
      frame_match <= 1'b0;
      frame_start_home <= 1'b0;
    end else if (enc_smp_in.valid) begin
      if (enc_smp_in.first) begin
        // A misplaced start abandons the current frame
        smp_cnt <= ONE_IDX;
        in_frame <= 1'b1;
        frame_match <= smp_is_home;
        frame_start_home <= enc_in_home;
      end else if (in_frame) begin
        smp_cnt <= smp_cnt + ONE_IDX;
        frame_match <= frame_match && smp_is_home;
        if (smp_cnt == LAST_IDX) begin
          in_frame <= 1'b0;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Encoder output and home state

  logic enc_pend;
  logic enc_pend_home;
  logic enc_pend_subst;
  logic [PAR_W-1:0] enc_ref;
  logic [PAR_W-1:0] enc_len_mask;

  assign enc_ref = DEC_HOME_FRAMES[enc_mode];
  assign enc_len_mask = len_mask(PAR_LEN[enc_mode]);

  // Remember what the finished input frame asks of its parameter frame
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      enc_pend <= 1'b0;
      enc_pend_home <= 1'b0;
      enc_pend_subst <= 1'b0;
    end else if (frame_end) begin
      enc_pend <= 1'b1;
      enc_pend_home <= enc_hit;
      enc_pend_subst <= enc_hit && frame_start_home;
    end else if (enc_par_in.valid) begin
      enc_pend <= 1'b0;
      enc_pend_home <= 1'b0;
      enc_pend_subst <= 1'b0;
    end
  end

  // Core result passes through, homing pattern replaces it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      enc_par_out <= '0;
    end else begin
      enc_par_out.valid <= enc_par_in.valid;
      if (enc_par_in.valid && enc_pend && enc_pend_subst) begin
        enc_par_out.bits <= enc_ref & enc_len_mask;
      end else if (enc_par_in.valid) begin
        enc_par_out.bits <= enc_par_in.bits & enc_len_mask;
      end
    end
  end

  // Detection pulse and sub-module home reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      enc_home_det <= 1'b0;
      enc_home_rst <= 1'b0;
    end else begin
      enc_home_det <= enc_hit;
      // Voice activity detector and transmission control go home too
      enc_home_rst <= enc_par_in.valid && enc_pend && enc_pend_home;
    end
  end

  // Home after reset or homing; lost by any other frame
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      enc_in_home <= 1'b1;
    end else begin
      if (enc_par_in.valid && enc_pend && enc_pend_home) begin
        enc_in_home <= 1'b1;
      end
      if (frame_end && !enc_hit) begin
        enc_in_home <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Decoder homing frame detection

  logic [PAR_W-1:0] dec_ref;
  logic [PAR_W-1:0] dec_diff;
  logic [PAR_W-1:0] dec_full_mask;
  logic [PAR_W-1:0] dec_early_mask;
  logic dec_full_hit;
  logic dec_early_hit;
  logic dec_hit;

  assign dec_ref = DEC_HOME_FRAMES[dec_mode];
  assign dec_diff = dec_par_in.bits ^ dec_ref;
  assign dec_full_mask = len_mask(PAR_LEN[dec_mode]);
  assign dec_early_mask = len_mask(EARLY_LEN[dec_mode]);
  assign dec_full_hit = ((dec_diff & dec_full_mask) == '0);
  // Relies on test sequences differing early
  assign dec_early_hit = ((dec_diff & dec_early_mask) == '0);
  assign dec_hit = dec_in_home ? dec_early_hit : dec_full_hit;

  logic dec_pend_home;
  logic dec_subst;

  // Per-frame flags held until the frame's last speech sample
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dec_pend_home <= 1'b0;
      dec_subst <= 1'b0;
    end else if (dec_par_in.valid) begin
      dec_pend_home <= dec_hit;
      dec_subst <= dec_hit && dec_in_home;
    end else if (dec_smp_in.valid && dec_smp_in.last) begin
      dec_pend_home <= 1'b0;
      dec_subst <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Decoder speech output and home state

  // Decoded speech replaced by the encoder homing frame
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dec_smp_out <= '0;
    end else begin
      dec_smp_out.valid <= dec_smp_in.valid;
      dec_smp_out.first <= dec_smp_in.valid && dec_smp_in.first;
      dec_smp_out.last <= dec_smp_in.valid && dec_smp_in.last;
      if (dec_smp_in.valid && dec_subst) begin
        dec_smp_out.data <= ENC_HOME_WORD;
      end else if (dec_smp_in.valid) begin
        dec_smp_out.data <= dec_smp_in.data;
      end
    end
  end

  // Detection pulse and sub-module home reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dec_home_det <= 1'b0;
      dec_home_rst <= 1'b0;
    end else begin
      dec_home_det <= dec_par_in.valid && dec_hit;
      // Comfort noise generator included
      dec_home_rst <= dec_smp_in.valid && dec_smp_in.last &&
                      dec_pend_home;
    end
  end

  // Home after reset or homing; lost by any other frame
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dec_in_home <= 1'b1;
    end else begin
      if (dec_smp_in.valid && dec_smp_in.last && dec_pend_home) begin
        dec_in_home <= 1'b1;
      end
      if (dec_par_in.valid && !dec_hit) begin
        dec_in_home <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// File: testbench/homing_properties.sv
// Port checks for the codec homing control block
`timescale 1ns/10ps
`default_nettype none
module homing_properties
  import homing_pkg::*;
#(
  parameter par_table_t DEC_HOME_FRAMES = DEC_HOME_DEFAULT
) (
  // Clock, reset, mode
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [MODE_W-1:0] enc_mode,
  // Encoder side
  input wire smp_t enc_smp_in,
  input wire par_t enc_par_in,
  input wire par_t enc_par_out,
  input wire logic enc_home_det,
  input wire logic enc_home_rst,
  input wire logic enc_in_home,
  // Decoder side
  input wire par_t dec_par_in,
  input wire smp_t dec_smp_out,
  input wire logic dec_home_det,
  input wire logic dec_home_rst,
  input wire logic dec_in_home
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence par_echo;
    ##1 enc_par_out.valid;
  endsequence
  chk_det_word: assert property (enc_home_det |->
    $past(enc_smp_in.valid && enc_smp_in.data == ENC_HOME_WORD))
    else $error("det without home word");
  chk_det_pulse: assert property (enc_home_det |=> !enc_home_det)
    else $error("det too long");
  chk_par_pass: assert property (enc_par_in.valid |-> par_echo)
    else $error("param frame lost");
  chk_enc_rst: assert property (enc_home_rst |->
    enc_in_home && enc_par_out.valid) else $error("enc home rst");
  chk_enc_sub: assert property (enc_home_rst &&
    $past(enc_in_home) |-> enc_par_out.bits == (DEC_HOME_FRAMES[enc_mode] &
    len_mask(PAR_LEN[enc_mode]))) else $error("enc substitution");
  chk_dec_det: assert property (dec_home_det |->
    $past(dec_par_in.valid)) else $error("dec det without frame");
  chk_dec_sub: assert property (dec_home_rst &&
    $past(dec_in_home) |-> dec_smp_out.data == ENC_HOME_WORD)
    else $error("dec substitution");
  chk_dec_rst: assert property (dec_home_rst |->
    dec_in_home && dec_smp_out.valid) else $error("dec home rst");
endmodule
bind codec_homing_control homing_properties #(
  .DEC_HOME_FRAMES(DEC_HOME_FRAMES)) chk (.*);
`default_nettype wire

// File: testbench/speech_src.sv
// Speech source sending whole aligned frames
`timescale 1ns/10ps
`default_nettype none
module speech_src
  import homing_pkg::*;
(
  // Clock and control
  input wire logic sys_clk,
  input wire logic go,
  input wire logic [WORD_BITS-1:0] word,
  // Samples out
  output smp_t smp,
  output logic busy
);
  int n = 0;
  initial smp = '0;
  always @(posedge sys_clk) begin
    if (go || n > 0) begin
      smp <= '{1'b1, n == 0, n == FRAME_SAMPLES - 1, word};
      n <= (n == FRAME_SAMPLES - 1) ? 0 : n + 1;
    end else begin
      smp <= '{1'b0, 1'b0, 1'b0, ~smp.data};
    end
  end
  assign busy = go || n > 0;
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the codec homing control block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import homing_pkg::*;
  logic sys_clk = 0, rstn = 0, go = 0;
  logic [MODE_W-1:0] enc_mode = '0, dec_mode = '0;
  logic [WORD_BITS-1:0] word = '0;
  smp_t enc_smp_in, dec_smp_in = '0, dec_smp_out;
  par_t enc_par_in = '0, dec_par_in = '0, enc_par_out;
  logic busy, enc_home_det, enc_home_rst, enc_in_home;
  logic dec_home_det, dec_home_rst, dec_in_home;
  int err_total = 0, n_tests = 0;
  codec_homing_control dut (.*);
  speech_src src (.sys_clk, .go, .word, .smp(enc_smp_in), .busy);
  initial forever #10 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [PAR_W-1:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h", $time, got);
    end
  endtask
  task automatic enc_frame(input logic [15:0] w, input logic d, int m);
    @(posedge sys_clk);
    word <= w;
    go <= 1'b1;
    enc_mode <= MODE_W'(m);
    @(posedge sys_clk);
    go <= 1'b0;
    for (int i = 0; i <= 200; i++) begin
      @(posedge sys_clk);
      #1;
      if (!busy) break;
      if (i == 200) begin
        err_total++;
        print_verdict();
      end
    end
    @(posedge sys_clk);
    #1;
    cmp(enc_home_det, d);
  endtask
  task automatic enc_par(input logic h, input logic r);
    @(posedge sys_clk);
    enc_par_in <= '{1'b1, {PAR_W{1'b1}}};
    @(posedge sys_clk);
    enc_par_in.valid <= 1'b0;
    #1;
    cmp(enc_par_out.valid, 1);
    cmp(enc_par_out.bits, h ? '0 :
      {PAR_W{1'b1}} >> (PAR_W - int'(PAR_LEN[enc_mode])));
    cmp(enc_home_rst, r);
    cmp(enc_in_home, r);
  endtask
  task automatic dec_frame(input logic [PAR_W-1:0] b, input logic d,
      input logic [15:0] w, int m);
    @(posedge sys_clk);
    dec_par_in <= '{1'b1, b};
    dec_mode <= MODE_W'(m);
    @(posedge sys_clk);
    dec_par_in.valid <= 1'b0;
    dec_smp_in <= '{1'b1, 1'b1, 1'b1, 16'h1234};
    #1;
    cmp(dec_home_det, d);
    @(posedge sys_clk);
    dec_smp_in <= '{1'b0, 1'b0, 1'b0, 16'hEDCB};
    #1;
    cmp(dec_smp_out.data, w);
    cmp({dec_smp_out.valid, dec_smp_out.last}, 2'b11);
    cmp(dec_home_rst, d);
    cmp(dec_in_home, d);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    #1;
    cmp(enc_in_home & dec_in_home, 1);
    enc_frame(16'h0008, 1, 0);
    enc_par(1, 1);
    enc_frame(16'h0001, 0, 0);
    enc_par(0, 0);
    enc_frame(16'h0008, 1, 5);
    enc_par(0, 1);
    dec_frame('0, 1, 16'h0008, 0);
    dec_frame(PAR_W'(1) << 60, 1, 16'h0008, 0);
    for (int m = 0; m < NUM_MODES; m++) begin
      dec_frame(1, 0, 16'h1234, m);
      dec_frame(PAR_W'(1) << PAR_LEN[m], 1, 16'h1234, m);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
